// *** design/prd_edge_delay.v ***
`timescale 1ns/1ps
`default_nettype none

module prd_edge_delay (
    input  wire       clk,
    input  wire       nrst,
    input  wire       insnTick,
    input  wire [6:0] delayCount,
    input  wire       schedIn,
    output wire       delayedOut
);

    reg       prevQ;
    reg       outQ;
    reg       pendQ;
    reg [6:0] cntQ;

    wire riseEvt = schedIn & ~prevQ;

    // ****************************************
    // Active edge delay
    // ****************************************
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prevQ <= 1'b0;
            outQ  <= 1'b0;
            pendQ <= 1'b0;
            cntQ  <= 7'h00;
        end else begin
            prevQ <= schedIn;
            if (!schedIn) begin
                outQ  <= 1'b0;
                pendQ <= 1'b0;
            end else if (riseEvt) begin
                if (delayCount == 7'h00) begin
                    outQ <= 1'b1;
                end else begin
                    pendQ <= 1'b1;
                    cntQ  <= delayCount;
                end
            end else if (pendQ && insnTick) begin
                if (cntQ == 7'h01) begin
                    outQ  <= 1'b1;
                    pendQ <= 1'b0;
                end
                cntQ <= cntQ - 7'h01;
            end
        end
    end

    assign delayedOut = outQ;

endmodule

`default_nettype wire

// *** design/prd_restart_delay.v ***
// Notes on behaviour
// - Restart enabled: flag clears itself when shutdown condition goes away.
// - Restart disabled: outputs stay shut down until software writes flag zero.
// - Active-going edge delayed by 7-bit count of instruction cycles.
// - Every reset clears all eight control bits to zero.
// - Shutdown drives each pin pair low, high or released per its field.
//
// The APB slave port and the address map were chosen for this implementation.
`include "prd_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module prd_restart_delay (
    input  wire        clk,
    input  wire        nrst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        shutdownPin,
    input  wire [3:0]  pwmSched,
    output reg  [3:0]  pinOut,
    output reg  [3:0]  pinOeN,
    output wire        shutdownActive
);

    // ****************************************
    // State
    // ****************************************
    reg  [7:0] ctrlQ;
    reg  [7:0] ctrlD;
    reg        flagQ;
    reg        flagD;
    reg  [1:0] acStateQ;
    reg  [1:0] acStateD;
    reg  [1:0] bdStateQ;
    reg  [1:0] bdStateD;
    reg        syncQ1;
    reg        syncQ2;
    reg  [`PRD_INSN_CNT_W-1:0] insnCntQ;
    reg  [3:0] pinOutD;
    reg  [3:0] pinOeND;
    reg  [31:0] rdD;

    wire       autoRestart;
    wire [6:0] delayCount;
    wire       insnTick;
    wire [3:0] delayedPwm;
    wire       setupPh;
    wire       accessPh;
    wire       wrAcc;
    wire       hitCtrl;
    wire       hitShdn;
    wire       hitStatus;
    wire       mapped;

    assign autoRestart = ctrlQ[`PRD_CTRL_RESTART_BIT];
    assign delayCount  = ctrlQ[`PRD_CTRL_DELAY_MSB:`PRD_CTRL_DELAY_LSB];

    // ****************************************
    // APB decode
    // ****************************************
    assign setupPh   = psel & ~penable;
    assign accessPh  = psel & penable;
    assign wrAcc     = accessPh & pwrite;
    assign hitCtrl   = (paddr == `PRD_OFS_CTRL);
    assign hitShdn   = (paddr == `PRD_OFS_SHDN);
    assign hitStatus = (paddr == `PRD_OFS_STATUS);
    assign mapped    = hitCtrl | hitShdn | hitStatus;
    assign pready    = 1'b1;
    assign pslverr   = accessPh & ~mapped;

    // ****************************************
    // Shutdown pin synchroniser
    // ****************************************
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            syncQ1 <= 1'b0;
            syncQ2 <= 1'b0;
        end else begin
            syncQ1 <= shutdownPin;
            syncQ2 <= syncQ1;
        end
    end

    // ****************************************
    // Instruction clock, four oscillator periods
    // ****************************************
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            insnCntQ <= {`PRD_INSN_CNT_W{1'b0}};
        end else begin
            insnCntQ <= insnCntQ + {{(`PRD_INSN_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    assign insnTick = (insnCntQ == `PRD_INSN_LAST);

    // ****************************************
    // Control register next value
    // ****************************************
    always @* begin
        ctrlD = ctrlQ;
        if (wrAcc && hitCtrl && pstrb[0]) begin
            ctrlD = pwdata[7:0];
        end
    end

    // ****************************************
    // Shutdown register next value
    // ****************************************
    always @* begin
        flagD    = flagQ;
        acStateD = acStateQ;
        bdStateD = bdStateQ;
        if (wrAcc && hitShdn && pstrb[0]) begin
            flagD    = pwdata[`PRD_SHDN_FLAG_BIT];
            acStateD = pwdata[`PRD_SHDN_AC_MSB:`PRD_SHDN_AC_LSB];
            bdStateD = pwdata[`PRD_SHDN_BD_MSB:`PRD_SHDN_BD_LSB];
        end
        if (autoRestart && flagQ && !syncQ2) begin
            flagD = 1'b0;
        end
        if (syncQ2) begin
            flagD = 1'b1;
        end
    end

    // ****************************************
    // Register update
    // ****************************************
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrlQ    <= `PRD_CTRL_RESET;
            flagQ    <= 1'b0;
            acStateQ <= 2'h0;
            bdStateQ <= 2'h0;
        end else begin
            ctrlQ    <= ctrlD;
            flagQ    <= flagD;
            acStateQ <= acStateD;
            bdStateQ <= bdStateD;
        end
    end

    assign shutdownActive = flagQ;

    // ****************************************
    // Read data, latched in setup phase
    // ****************************************
    always @* begin
        rdD = 32'h0000_0000;
        if (hitCtrl) begin
            rdD[7:0] = ctrlQ;
        end else if (hitShdn) begin
            rdD[`PRD_SHDN_FLAG_BIT]                    = flagQ;
            rdD[`PRD_SHDN_AC_MSB:`PRD_SHDN_AC_LSB]     = acStateQ;
            rdD[`PRD_SHDN_BD_MSB:`PRD_SHDN_BD_LSB]     = bdStateQ;
        end else if (hitStatus) begin
            rdD[3:0] = delayedPwm;
            rdD[4]   = syncQ2;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (setupPh && !pwrite) begin
            prdata <= rdD;
        end
    end

    // ****************************************
    // Per-pin active edge delay
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : gPin
            prd_edge_delay uDelay (
                .clk        (clk),
                .nrst       (nrst),
                .insnTick   (insnTick),
                .delayCount (delayCount),
                .schedIn    (pwmSched[gi]),
                .delayedOut (delayedPwm[gi])
            );
        end
    endgenerate

    // ****************************************
    // Output pin drive
    // ****************************************
    always @* begin
        pinOutD = delayedPwm;
        pinOeND = 4'h0;
        if (flagQ) begin
            // Pins 0 and 2 form pair AC, pins 1 and 3 pair BD
            if (acStateQ == `PRD_SS_LOW) begin
                pinOutD[0] = 1'b0;
                pinOutD[2] = 1'b0;
            end else if (acStateQ == `PRD_SS_HIGH) begin
                pinOutD[0] = 1'b1;
                pinOutD[2] = 1'b1;
            end else begin
                pinOutD[0] = 1'b0;
                pinOutD[2] = 1'b0;
                pinOeND[0] = 1'b1;
                pinOeND[2] = 1'b1;
            end
            if (bdStateQ == `PRD_SS_LOW) begin
                pinOutD[1] = 1'b0;
                pinOutD[3] = 1'b0;
            end else if (bdStateQ == `PRD_SS_HIGH) begin
                pinOutD[1] = 1'b1;
                pinOutD[3] = 1'b1;
            end else begin
                pinOutD[1] = 1'b0;
                pinOutD[3] = 1'b0;
                pinOeND[1] = 1'b1;
                pinOeND[3] = 1'b1;
            end
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pinOut <= 4'h0;
            pinOeN <= 4'h0;
        end else begin
            pinOut <= pinOutD;
            pinOeN <= pinOeND;
        end
    end

endmodule

`default_nettype wire

// *** include/prd_consts.vh ***
`ifndef PRD_CONSTS_VH
`define PRD_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define PRD_OFS_CTRL          12'h000
`define PRD_OFS_SHDN          12'h004
`define PRD_OFS_STATUS        12'h008

// ****************************************
// Control register fields
// ****************************************
`define PRD_CTRL_RESTART_BIT  7
`define PRD_CTRL_DELAY_MSB    6
`define PRD_CTRL_DELAY_LSB    0
`define PRD_CTRL_RESET        8'h00

// ****************************************
// Shutdown register fields
// ****************************************
`define PRD_SHDN_FLAG_BIT     7
`define PRD_SHDN_AC_MSB       3
`define PRD_SHDN_AC_LSB       2
`define PRD_SHDN_BD_MSB       1
`define PRD_SHDN_BD_LSB       0
`define PRD_SHDN_RESET        8'h00

// ****************************************
// Shutdown pin state codes
// ****************************************
`define PRD_SS_LOW            2'h0
`define PRD_SS_HIGH           2'h1

// ****************************************
// Timing
// ****************************************
`define PRD_TOSC_PER_INSN     4
`define PRD_INSN_CNT_W        2
`define PRD_INSN_LAST         2'h3

`endif

// *** tb/prd_restart_delay_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// ********
// Checker
// ********
module prd_restart_delay_asserts (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        shutdownPin,
    input wire logic [3:0]  pwmSched,
    input wire logic [3:0]  pinOut,
    input wire logic [3:0]  pinOeN,
    input wire logic        shutdownActive
);
    logic [7:0] ctrlQ;
    logic [3:0] shdnQ;
    logic       s1Q;
    logic       s2Q;
    logic [9:0] waitQ;
    wire        acc    = psel & penable & pwrite & pstrb[0];
    wire        wrShdn = acc && paddr == 12'h004;
    wire  [9:0] dly4   = {1'b0, ctrlQ[6:0], 2'b00};
    wire  [3:0] expOe  = {shdnQ[1], shdnQ[3], shdnQ[1], shdnQ[3]};
    wire        aHi    = ~shdnQ[3] & shdnQ[2];
    wire        bHi    = ~shdnQ[1] & shdnQ[0];
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrlQ <= 8'h00;
            shdnQ <= 4'h0;
            s1Q   <= 1'b0;
            s2Q   <= 1'b0;
            waitQ <= 10'h000;
        end else begin
            if (acc && paddr == 12'h000) ctrlQ <= pwdata[7:0];
            if (wrShdn) shdnQ <= pwdata[3:0];
            s1Q   <= shutdownPin;
            s2Q   <= s1Q;
            waitQ <= !pwmSched[1] ? 10'h000 : (waitQ == 10'h3ff ? waitQ : waitQ + 10'h001);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_SET: assert property (s2Q |=> shutdownActive) else $error("flag not set");
    AST_AUTO_CLR: assert property (ctrlQ[7] && !s2Q && !wrShdn |=> !shutdownActive) else $error("no auto clear");
    AST_HOLD: assert property (!ctrlQ[7] && shutdownActive && !wrShdn |=> shutdownActive) else $error("flag lost");
    AST_SW_CLR: assert property (wrShdn && !pwdata[7] && !s2Q |=> !shutdownActive) else $error("no sw clear");
    AST_EARLY: assert property (pwmSched[1] && waitQ >= 10'd2 && waitQ + 10'd2 < dly4 && !$past(shutdownActive)
        |-> !pinOut[1]) else $error("edge too early");
    AST_LATE: assert property (pwmSched[1] && dly4 != 10'd0 && waitQ == dly4 + 10'd2 && !$past(shutdownActive)
        |-> pinOut[1]) else $error("edge too late");
    AST_RST: assert property (disable iff (1'b0) !nrst |-> prdata == 32'h0 && !shutdownActive) else $error("reset");
    AST_PINS: assert property (shutdownActive && !wrShdn |=> pinOeN == expOe && pinOut == {bHi, aHi, bHi, aHi})
        else $error("shutdown pins");
    AST_ZERO: assert property ($rose(pwmSched[0]) && ctrlQ[6:0] == 7'h00 ##1 !shutdownActive |=> pinOut[0])
        else $error("zero delay");
    AST_FALL: assert property ($fell(pwmSched[0]) ##1 !shutdownActive |=> !pinOut[0]) else $error("fall delayed");
    cover property (shutdownActive && ctrlQ[7]);
    cover property ($fell(shutdownActive));
    cover property ($rose(pinOut[1]) && ctrlQ[6:0] != 7'h00);
endmodule
bind prd_restart_delay prd_restart_delay_asserts i_prd_restart_delay_asserts (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .shutdownPin(shutdownPin), .pwmSched(pwmSched), .pinOut(pinOut),
    .pinOeN(pinOeN), .shutdownActive(shutdownActive));
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ********
// Bench
// ********
module tb_top;
    logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, shutdownPin = 1'b0, err, ok;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, seed = 32'habe0, rd;
    logic [3:0]  pstrb = 4'hf, pwmSched = 4'h0;
    logic [6:0]  n;
    wire         pready, pslverr, shutdownActive;
    wire  [31:0] prdata;
    wire  [3:0]  pinOut, pinOeN;
    int          fails = 0, n_checks = 0, cyc = 0, k;
    prd_restart_delay i_prd_restart_delay (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .shutdownPin(shutdownPin), .pwmSched(pwmSched), .pinOut(pinOut), .pinOeN(pinOeN),
        .shutdownActive(shutdownActive));
    always #10 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] expShut(input logic [1:0] ac, input logic [1:0] bd);
        logic a, b;
        a = ~ac[1] & ac[0];
        b = ~bd[1] & bd[0];
        return {24'h0, bd[1], ac[1], bd[1], ac[1], b, a, b, a};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic shut(input logic rs, input logic [1:0] ac, input logic [1:0] bd);
        apb(1'b1, 12'h000, {24'h0, rs, 7'h00});
        apb(1'b1, 12'h004, {28'h0, ac, bd});
        @(posedge clk) shutdownPin <= 1'b1;
        repeat (6) @(posedge clk);
        #1 chk({31'h0, shutdownActive}, 32'h1);
        chk({24'h0, pinOeN, pinOut}, expShut(ac, bd));
        @(posedge clk) shutdownPin <= 1'b0;
        repeat (6) @(posedge clk);
        #1 chk({31'h0, shutdownActive}, {31'h0, ~rs});
        if (!rs) begin
            apb(1'b1, 12'h004, {28'h0, ac, bd});
            @(posedge clk);
            #1 chk({31'h0, shutdownActive}, 32'h0);
        end
        repeat (2) @(posedge clk);
        #1 chk({24'h0, pinOeN, pinOut}, 32'h0);
    endtask
    task automatic close_out();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h0);
        apb(1'b0, 12'h004, 32'h0); chk(rd, 32'h0);
        $display("test reset done");
        repeat (4) begin
            seed = lfsr(seed);
            apb(1'b1, 12'h000, seed);
            apb(1'b0, 12'h000, 32'h0); chk(rd, {24'h0, seed[7:0]});
        end
        apb(1'b0, 12'h00c, 32'h0); chk({31'h0, err}, 32'h1);
        $display("test regs done");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            n = (i == 0) ? 7'h00 : (i == 1) ? 7'h01 : (i == 2) ? 7'h7f : seed[6:0];
            apb(1'b1, 12'h000, {25'h0, n});
            @(posedge clk) pwmSched <= 4'hf;
            k = 0;
            do begin @(posedge clk); #1 k++; end while (pinOut[0] !== 1'b1 && k < 600);
            ok = (n == 7'h00) ? (k == 2) : (k >= 4 * n - 2 && k <= 4 * n + 1);
            chk({31'h0, ok}, 32'h1);
            chk({28'h0, pinOut}, 32'hf);
            @(posedge clk) pwmSched <= 4'h0;
            repeat (2) @(posedge clk);
            #1 chk({28'h0, pinOut}, 32'h0);
        end
        $display("test delay done");
        for (int c = 0; c < 8; c++) shut(c[2], c[1:0], ~c[1:0]);
        $display("test shutdown done");
        @(posedge clk) nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h0);
        $display("test second reset done");
        close_out();
    end
endmodule
`default_nettype wire
